// ===== verilog/srt_ctrl.v
// Host controller for the serial port and row transfers of a video DRAM
`timescale 1ns/100ps
`include "srt_consts.vh"
module srt_ctrl #(
  parameter ADDR_W = 9,
  parameter DATA_W = 8
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // Transfer command port
  input wire i_cmd_valid,
  input wire [1:0] i_cmd_kind,
  input wire [ADDR_W-1:0] i_cmd_row,
  input wire [ADDR_W-1:0] i_cmd_col,
  output wire o_cmd_ready,
  output reg o_cmd_err,
  output reg o_cmd_done,
  // Serial stream port
  input wire i_shift_en,
  input wire i_wr_valid,
  input wire [DATA_W-1:0] i_wr_data,
  output wire o_wr_ready,
  output reg o_rd_valid,
  output reg [DATA_W-1:0] o_rd_data,
  output wire o_dir_out,
  output wire o_half,
  // Device strobes and address
  output reg o_row_strobe_n,
  output reg o_col_strobe_n,
  output reg o_write_en_n,
  output reg o_transfer_gate_n,
  output reg o_function_select,
  output reg [ADDR_W-1:0] o_addr,
  // Device array data pins
  output wire [DATA_W-1:0] o_dq,
  output reg o_dq_oe,
  // Device serial port
  output reg o_shift_clock,
  input wire [DATA_W-1:0] i_serial_data_pins,
  output reg [DATA_W-1:0] o_serial_data_pins,
  output wire o_serial_data_pins_oe,
  input wire i_half_indicator
);
  localparam [7:0] SETUP_CYC = `SRT_CYC(`SRT_SETUP_NS);
  localparam [7:0] ROW_CYC = `SRT_CYC(`SRT_ROW_TO_COL_NS);
  localparam [7:0] COL_CYC = `SRT_CYC(`SRT_CAS_LOW_NS);
  localparam [7:0] GATE_CYC = `SRT_CYC(`SRT_ROW_TO_GATE_HOLD_NS);
  localparam [7:0] PRECH_CYC = `SRT_CYC(`SRT_PRECHARGE_NS);
  localparam [7:0] GTS_CYC = `SRT_CYC(`SRT_GATE_TO_SHIFT_DELAY_NS);
  localparam [7:0] CTS_CYC = `SRT_CYC(`SRT_COLUMN_TO_SHIFT_DELAY_NS);
  localparam [3:0] HALF_CYC = `SRT_SHIFT_HALF;

  wire [DATA_W:0] sync_q;
  wire [DATA_W-1:0] sdq_sync;
  wire half_sync;

  srt_sync #(
    .W(DATA_W + 1)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_d({i_half_indicator, i_serial_data_pins}),
    .o_q(sync_q)
  );

  assign sdq_sync = sync_q[DATA_W-1:0];
  assign half_sync = sync_q[DATA_W];
  assign o_half = half_sync;

  reg [2:0] state_r;
  reg [7:0] wait_r;
  reg [7:0] hold_r;
  reg [1:0] kind_r;
  reg [ADDR_W-1:0] col_r;
  reg dir_in_r;
  reg full_done_r;
  reg read_top_valid_r;
  reg read_top_r;
  reg [3:0] div_r;
  reg wr_full_r;

  wire is_write = kind_r[`SRT_XFER_WR_BIT];
  wire is_half = kind_r[`SRT_XFER_HALF_BIT];
  wire cmd_half = i_cmd_kind[`SRT_XFER_HALF_BIT];
  wire cmd_write = i_cmd_kind[`SRT_XFER_WR_BIT];
  wire cmd_top = i_cmd_row[ADDR_W-1];

  // Half transfers need a direction set by a full one first
  wire bad_half = cmd_half && !full_done_r;
  // Write-back may not cross the row top bit of the loaded data
  wire bad_side = cmd_write && read_top_valid_r && (cmd_top != read_top_r);
  wire take = i_cmd_valid && (state_r == `SRT_ST_IDLE);

  assign o_cmd_ready = (state_r == `SRT_ST_IDLE);

  // Full transfers freeze the shift clock for the whole strobe cycle and the delay after
  wire full_busy = (state_r != `SRT_ST_IDLE) && !is_half;
  wire shift_ok = full_done_r && !full_busy && (hold_r == 8'h00);
  wire tick = (div_r == HALF_CYC - 4'h1);
  wire rise_ok = shift_ok && (dir_in_r ? wr_full_r : i_shift_en);

  assign o_dir_out = full_done_r && !dir_in_r;
  assign o_serial_data_pins_oe = full_done_r && dir_in_r;
  assign o_wr_ready = full_done_r && dir_in_r && !wr_full_r;
  assign o_dq = {DATA_W{1'b0}};

  // Transfer sequencer
  always @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      state_r <= `SRT_ST_IDLE;
      wait_r <= 8'h00;
      kind_r <= `SRT_XFER_READ;
      col_r <= {ADDR_W{1'b0}};
      dir_in_r <= 1'b0;
      full_done_r <= 1'b0;
      read_top_valid_r <= 1'b0;
      read_top_r <= 1'b0;
      o_cmd_err <= 1'b0;
      o_cmd_done <= 1'b0;
      o_row_strobe_n <= 1'b1;
      o_col_strobe_n <= 1'b1;
      o_write_en_n <= 1'b1;
      o_transfer_gate_n <= 1'b1;
      o_function_select <= 1'b0;
      o_addr <= {ADDR_W{1'b0}};
      o_dq_oe <= 1'b0;
    end
    else
    begin
      o_cmd_err <= 1'b0;
      o_cmd_done <= 1'b0;
      if (wait_r != 8'h00)
      begin
        wait_r <= wait_r - 8'h01;
      end
      case (state_r)
        `SRT_ST_IDLE:
        begin
          if (take)
          begin
            if (bad_half || bad_side)
            begin
              o_cmd_err <= 1'b1;
            end
            else
            begin
              kind_r <= i_cmd_kind;
              col_r <= i_cmd_col;
              o_addr <= i_cmd_row;
              o_transfer_gate_n <= 1'b0;
              o_col_strobe_n <= 1'b1;
              o_write_en_n <= !cmd_write;
              o_function_select <= cmd_half;
              o_dq_oe <= cmd_write;
              wait_r <= SETUP_CYC;
              state_r <= `SRT_ST_SETUP;
              // Stop driving the serial pins before the device turns them round
              if (!cmd_write && !cmd_half)
              begin
                dir_in_r <= 1'b0;
              end
              if (!cmd_write)
              begin
                read_top_r <= cmd_top;
                read_top_valid_r <= 1'b1;
              end
            end
          end
        end
        `SRT_ST_SETUP:
        begin
          // A full transfer waits for the shift clock to sit low
          if (wait_r == 8'h00 && (is_half || !o_shift_clock))
          begin
            o_row_strobe_n <= 1'b0;
            wait_r <= ROW_CYC;
            state_r <= `SRT_ST_ROW;
          end
        end
        `SRT_ST_ROW:
        begin
          o_dq_oe <= 1'b0;
          o_addr <= col_r;
          if (wait_r == 8'h00)
          begin
            o_col_strobe_n <= 1'b0;
            wait_r <= COL_CYC;
            state_r <= `SRT_ST_COL;
          end
        end
        `SRT_ST_COL:
        begin
          if (wait_r == 8'h00)
          begin
            wait_r <= GATE_CYC;
            state_r <= `SRT_ST_GATE;
          end
        end
        `SRT_ST_GATE:
        begin
          if (wait_r == 8'h00)
          begin
            o_transfer_gate_n <= 1'b1;
            o_row_strobe_n <= 1'b1;
            o_col_strobe_n <= 1'b1;
            o_write_en_n <= 1'b1;
            o_function_select <= 1'b0;
            wait_r <= PRECH_CYC;
            state_r <= `SRT_ST_PRECH;
            if (!is_half)
            begin
              full_done_r <= 1'b1;
              dir_in_r <= is_write;
            end
          end
        end
        `SRT_ST_PRECH:
        begin
          if (wait_r == 8'h00)
          begin
            o_cmd_done <= 1'b1;
            state_r <= `SRT_ST_IDLE;
          end
        end
        default:
        begin
          state_r <= `SRT_ST_IDLE;
        end
      endcase
    end
  end

  // Shift hold after a full transfer, counted from gate rise or column fall
  always @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      hold_r <= 8'h00;
    end
    else if (state_r == `SRT_ST_GATE && wait_r == 8'h00 && !is_half && !is_write)
    begin
      hold_r <= GTS_CYC;
    end
    else if (state_r == `SRT_ST_ROW && wait_r == 8'h00 && !is_half && is_write)
    begin
      hold_r <= CTS_CYC + COL_CYC + GATE_CYC + `SRT_WR_HOLD_PAD_CYC;
    end
    else if (hold_r != 8'h00)
    begin
      hold_r <= hold_r - 8'h01;
    end
  end

  // Shift clock divider and serial byte transfer; one location per rise
  always @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      div_r <= 4'h0;
      o_shift_clock <= 1'b0;
      wr_full_r <= 1'b0;
      o_serial_data_pins <= {DATA_W{1'b0}};
      o_rd_valid <= 1'b0;
      o_rd_data <= {DATA_W{1'b0}};
    end
    else
    begin
      o_rd_valid <= 1'b0;
      div_r <= tick ? 4'h0 : div_r + 4'h1;
      if (o_wr_ready && i_wr_valid)
      begin
        o_serial_data_pins <= i_wr_data;
        wr_full_r <= 1'b1;
      end
      if (tick)
      begin
        if (o_shift_clock)
        begin
          o_shift_clock <= 1'b0;
          // Output data has had a full high phase to settle through the synchroniser
          if (!dir_in_r)
          begin
            o_rd_valid <= 1'b1;
            o_rd_data <= sdq_sync;
          end
          else
          begin
            wr_full_r <= 1'b0;
          end
        end
        else if (rise_ok)
        begin
          o_shift_clock <= 1'b1;
        end
      end
    end
  end
endmodule // srt_ctrl

// ===== pkg/srt_consts.vh
// Constants for the serial-port row-transfer controller
`ifndef SRT_CONSTS_VH
`define SRT_CONSTS_VH

// Own clock period in ns
`define SRT_CLK_NS 50

// Strobe timing in ns (least times, rounded up to cycles)
`define SRT_SETUP_NS 50
`define SRT_ROW_TO_COL_NS 100
`define SRT_CAS_LOW_NS 100
`define SRT_ROW_TO_GATE_HOLD_NS 100
`define SRT_PRECHARGE_NS 100
`define SRT_GATE_TO_SHIFT_DELAY_NS 100
`define SRT_COLUMN_TO_SHIFT_DELAY_NS 150

// Cycles derived from the times above
`define SRT_CYC(ns) (((ns) + `SRT_CLK_NS - 1) / `SRT_CLK_NS)

// Extra cycles of write shift hold, covering the state steps after column fall
`define SRT_WR_HOLD_PAD_CYC 8'h02

// Shift clock half period in own clock cycles
`define SRT_SHIFT_HALF 4

// Transfer kinds on the command port; bit 0 selects write, bit 1 selects half-row
`define SRT_XFER_READ 2'h0
`define SRT_XFER_WRITE 2'h1
`define SRT_XFER_HALF_READ 2'h2
`define SRT_XFER_HALF_WRITE 2'h3
`define SRT_XFER_WR_BIT 0
`define SRT_XFER_HALF_BIT 1

// Sequencer states
`define SRT_ST_IDLE 3'h0
`define SRT_ST_SETUP 3'h1
`define SRT_ST_ROW 3'h2
`define SRT_ST_COL 3'h3
`define SRT_ST_GATE 3'h4
`define SRT_ST_PRECH 3'h5

`endif

// ===== verilog/srt_sync.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module srt_sync #(
  parameter W = 9
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // Data
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;
endmodule // srt_sync

// ===== verif/srt_ctrl_sva.sv
// Checker for the controller's device pins
`timescale 1ns/100ps
module srt_ctrl_sva (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // Watched outputs
  input wire o_cmd_done,
  input wire o_dir_out,
  input wire o_row_strobe_n,
  input wire o_col_strobe_n,
  input wire o_write_en_n,
  input wire o_transfer_gate_n,
  input wire o_function_select,
  input wire [8:0] o_addr,
  input wire [7:0] o_dq,
  input wire o_dq_oe,
  input wire o_shift_clock
);
  reg full_r;
  reg we_r;
  reg rbit_r;
  reg rdok_r;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  always @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      full_r <= 1'h0;
      rdok_r <= 1'h0;
    end
    else if ($fell(o_row_strobe_n))
    begin
      full_r <= !o_function_select;
      we_r <= o_write_en_n;
      if (o_write_en_n)
      begin
        rdok_r <= 1'h1;
        rbit_r <= o_addr[8];
      end
    end
  end
  sequence s_sc_high;
    o_shift_clock [*4] ##1 !o_shift_clock;
  endsequence
  a_row_fall: assert property ($fell(o_row_strobe_n) |-> !o_transfer_gate_n)
    else $error("gate not low at row fall");
  a_mask_zero: assert property ($fell(o_row_strobe_n) && !o_write_en_n |->
    o_dq_oe && o_dq == 8'h00) else $error("mask not zero");
  a_no_shift: assert property (!o_row_strobe_n && !o_function_select |->
    !$rose(o_shift_clock)) else $error("shift during transfer");
  a_gate_shift: assert property ($rose(o_transfer_gate_n) && full_r && we_r |=>
    !$rose(o_shift_clock) [*2]) else $error("shift too soon after gate");
  a_col_shift: assert property ($fell(o_col_strobe_n) && !o_write_en_n && full_r |=>
    !$rose(o_shift_clock) [*3]) else $error("shift too soon after column");
  a_sc_period: assert property ($rose(o_shift_clock) |-> s_sc_high)
    else $error("shift clock period wrong");
  a_dir_follow: assert property (o_cmd_done && full_r |=> o_dir_out == we_r)
    else $error("direction wrong");
  a_wb_bit: assert property ($fell(o_row_strobe_n) && !o_write_en_n && rdok_r |->
    o_addr[8] == rbit_r) else $error("write side differs");
endmodule // srt_ctrl_sva
bind srt_ctrl srt_ctrl_sva u_sva (
  .i_ref_clk(i_ref_clk),
  .i_resetn(i_resetn),
  .o_cmd_done(o_cmd_done),
  .o_dir_out(o_dir_out),
  .o_row_strobe_n(o_row_strobe_n),
  .o_col_strobe_n(o_col_strobe_n),
  .o_write_en_n(o_write_en_n),
  .o_transfer_gate_n(o_transfer_gate_n),
  .o_function_select(o_function_select),
  .o_addr(o_addr),
  .o_dq(o_dq),
  .o_dq_oe(o_dq_oe),
  .o_shift_clock(o_shift_clock)
);

// ===== verif/srt_dev_model.sv
// Behavioural serial buffer and transfer decode of the memory
`timescale 1ns/100ps
module srt_dev (
  // Strobes and address
  input wire i_row_n,
  input wire i_col_n,
  input wire i_we_n,
  input wire i_gate_n,
  input wire i_fsel,
  input wire [8:0] i_addr,
  // Serial port
  input wire i_sc,
  input wire [7:0] i_sd,
  output wire [7:0] o_sd,
  output wire o_half
);
  reg [7:0] serial_buffer [0:511];
  reg [7:0] sd_r = 8'h00;
  reg [8:0] ptr = 9'h000;
  reg [8:0] tap = 9'h000;
  reg [8:0] row = 9'h000;
  reg xf = 1'h0;
  reg rd = 1'h0;
  reg half = 1'h0;
  reg dir = 1'h0;
  reg split = 1'h0;
  integer k;
  // Released lines show the inverse, so stale data never reads as valid
  assign o_sd = dir ? sd_r : ~sd_r;
  assign o_half = ptr[8];
  always @(negedge i_row_n)
  begin
    xf = !i_gate_n;
    rd = i_we_n;
    half = i_fsel;
    row = i_addr;
  end
  always @(negedge i_col_n)
    if (xf)
      tap = i_addr;
  // Array side of write transfers is not kept
  always @(posedge i_gate_n)
    if (xf)
    begin
      xf = 1'h0;
      if (rd)
        for (k = 0; k < 512; k = k + 1)
          if (!half || k[8] != ptr[8])
            serial_buffer[k] = row[7:0] ^ k[7:0];
      if (!half)
      begin
        ptr = tap;
        dir = rd;
        split = 1'h0;
      end
      else
        split = 1'h1;
    end
  always @(posedge i_sc)
    if (!xf || half)
    begin
      if (dir)
        sd_r = serial_buffer[ptr];
      else
        serial_buffer[ptr] = i_sd;
      // Split mode leaves a half at its top for the start chosen in the other half
      if (split && ptr[7:0] == 8'hff)
        ptr = {~ptr[8], tap[7:0]};
      else
        ptr = ptr + 9'h001;
    end
endmodule // srt_dev

// ===== verif/srt_ctrl_test.sv
// Testbench for the row-transfer controller
`timescale 1ns/100ps
module srt_ctrl_test;
  reg i_ref_clk = 1'h0;
  reg i_resetn = 1'h0;
  reg i_cmd_valid = 1'h0;
  reg [1:0] i_cmd_kind = 2'h0;
  reg [8:0] i_cmd_row = 9'h000;
  reg [8:0] i_cmd_col = 9'h000;
  reg i_shift_en = 1'h0;
  reg i_wr_valid = 1'h0;
  reg [7:0] i_wr_data = 8'h00;
  wire o_cmd_ready, o_cmd_err, o_cmd_done, o_wr_ready, o_rd_valid, o_dir_out, o_half;
  wire o_row_strobe_n, o_col_strobe_n, o_write_en_n, o_transfer_gate_n;
  wire o_function_select, o_dq_oe, o_shift_clock, o_serial_data_pins_oe, i_half_indicator;
  wire [8:0] o_addr;
  wire [7:0] o_rd_data, o_dq, o_serial_data_pins, i_serial_data_pins, dev_sd;
  integer err_total = 0;
  integer compares = 0;
  integer cyc = 0;
  integer n;
  assign i_serial_data_pins = o_serial_data_pins_oe ? o_serial_data_pins : dev_sd;
  srt_ctrl dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_cmd_valid(i_cmd_valid), .i_cmd_kind(i_cmd_kind), .i_cmd_row(i_cmd_row),
    .i_cmd_col(i_cmd_col), .o_cmd_ready(o_cmd_ready), .o_cmd_err(o_cmd_err),
    .o_cmd_done(o_cmd_done), .i_shift_en(i_shift_en), .i_wr_valid(i_wr_valid),
    .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_dir_out(o_dir_out), .o_half(o_half),
    .o_row_strobe_n(o_row_strobe_n), .o_col_strobe_n(o_col_strobe_n),
    .o_write_en_n(o_write_en_n), .o_transfer_gate_n(o_transfer_gate_n),
    .o_function_select(o_function_select), .o_addr(o_addr), .o_dq(o_dq),
    .o_dq_oe(o_dq_oe), .o_shift_clock(o_shift_clock),
    .i_serial_data_pins(i_serial_data_pins), .o_serial_data_pins(o_serial_data_pins),
    .o_serial_data_pins_oe(o_serial_data_pins_oe), .i_half_indicator(i_half_indicator));
  srt_dev dev (.i_row_n(o_row_strobe_n), .i_col_n(o_col_strobe_n), .i_we_n(o_write_en_n),
    .i_gate_n(o_transfer_gate_n), .i_fsel(o_function_select), .i_addr(o_addr),
    .i_sc(o_shift_clock), .i_sd(i_serial_data_pins), .o_sd(dev_sd),
    .o_half(i_half_indicator));
  initial forever #25 i_ref_clk = ~i_ref_clk;
  task final_report;
  begin
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  always @(posedge i_ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      final_report;
    end
  end
  task step;
  begin
    @(posedge i_ref_clk);
    #1;
    n = n + 1;
  end
  endtask
  task check(input [63:0] name, input [15:0] got, input [15:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("unexpected %0s exp %h got %h", name, exp, got);
    end
  end
  endtask
  task cmd(input [1:0] k, input [8:0] r, input [8:0] c, input bad);
  begin
    n = 0;
    while (o_cmd_ready !== 1'h1 && n < 100)
      step;
    i_cmd_valid = 1'h1;
    i_cmd_kind = k;
    i_cmd_row = r;
    i_cmd_col = c;
    step;
    i_cmd_valid = 1'h0;
    n = 0;
    while (o_cmd_err !== 1'h1 && o_cmd_done !== 1'h1 && n < 200)
      step;
    check("refused", o_cmd_err, bad);
    check("done", o_cmd_done, !bad);
    check("ready", o_cmd_ready, 1'h1);
  end
  endtask
  task rd(input [7:0] e);
  begin
    n = 0;
    step;
    while (o_rd_valid !== 1'h1 && n < 100)
      step;
    check("rd_data", o_rd_data, e);
  end
  endtask
  task t_read;
  begin
    cmd(2'h2, 9'h000, 9'h000, 1'h1);
    cmd(2'h0, 9'h0a5, 9'h1fe, 1'h0);
    check("dir", o_dir_out, 1'h1);
    i_shift_en = 1'h1;
    rd(8'h5b);
    rd(8'h5a);
    rd(8'ha5);
    i_shift_en = 1'h0;
  end
  endtask
  task t_half;
  begin
    cmd(2'h0, 9'h011, 9'h0fe, 1'h0);
    cmd(2'h2, 9'h033, 9'h110, 1'h0);
    check("dir", o_dir_out, 1'h1);
    i_shift_en = 1'h1;
    rd(8'hef);
    check("half", o_half, 1'h0);
    rd(8'hee);
    check("half", o_half, 1'h1);
    rd(8'h23);
    i_shift_en = 1'h0;
    cmd(2'h1, 9'h1a0, 9'h000, 1'h1);
  end
  endtask
  task t_write;
  begin
    cmd(2'h1, 9'h020, 9'h005, 1'h0);
    check("dir", o_dir_out, 1'h0);
    check("sd_oe", o_serial_data_pins_oe, 1'h1);
    n = 0;
    while (o_wr_ready !== 1'h1 && n < 100)
      step;
    i_wr_valid = 1'h1;
    i_wr_data = 8'h3c;
    step;
    check("wr_ready", o_wr_ready, 1'h0);
    i_wr_valid = 1'h0;
    n = 0;
    while (dev.ptr !== 9'h006 && n < 100)
      step;
    check("buffer", dev.serial_buffer[5], 8'h3c);
    cmd(2'h1, 9'h021, 9'h000, 1'h0);
    cmd(2'h3, 9'h022, 9'h100, 1'h0);
    check("dir", o_dir_out, 1'h0);
  end
  endtask
  task t_reread;
  begin
    cmd(2'h0, 9'h044, 9'h010, 1'h0);
    check("dir", o_dir_out, 1'h1);
    i_shift_en = 1'h1;
    rd(8'h54);
    i_shift_en = 1'h0;
  end
  endtask
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    #1;
    i_resetn = 1'h1;
    t_read;
    t_half;
    t_write;
    t_reread;
    final_report;
  end
endmodule // srt_ctrl_test
